// ==== tear_sync_out.sv ====
// Tearing-sync output generator top level
`timescale 1ns/100ps
module tear_sync_output
	import tear_sync_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic TEAR_ON_CMD,
	input wire logic TEAR_OFF_CMD,
	input wire logic TEAR_MODE_PARAM,
	input wire logic SLEEP_IN,
	input wire logic [PORCH_W-1:0] BACK_PORCH_LINES,
	input wire logic [PORCH_W-1:0] FRONT_PORCH_LINES,
	input wire logic [CNT_W-1:0] LINE_CYCLES,
	input wire logic [CNT_W-1:0] LINE_HBLANK_CYCLES,
	output logic TEAR_SYNC_OUT,
	output logic TEAR_ENABLED,
	output logic TEAR_MODE
);
	logic en_q;
	tear_mode_t mode_q;
	logic out_q;
	logic out_d;
	logic line_end;
	logic in_hblank;
	logic [LINE_W-1:0] line_idx;
	scan_state_t state;
	logic [CNT_W-1:0] hblank_eff;
	logic vblank;

	// Clamp line high time to its ceiling
	assign hblank_eff = (LINE_HBLANK_CYCLES > CNT_W'(LINE_HIGH_MAX_CYC)) ?
		CNT_W'(LINE_HIGH_MAX_CYC) : LINE_HBLANK_CYCLES;

	scan_timer u_scan (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.line_cyc(LINE_CYCLES),
		.line_hblank(hblank_eff),
		.back_porch_lines(BACK_PORCH_LINES),
		.front_porch_lines(FRONT_PORCH_LINES),
		.line_end(line_end),
		.in_hblank(in_hblank),
		.line_idx(line_idx),
		.state(state)
	);

	////////////////////////////////////////////////////////////////////
	// Enable and mode from host commands
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			en_q <= 1'b0;
		end else if (TEAR_ON_CMD) begin
			en_q <= 1'b1;
		end else if (TEAR_OFF_CMD) begin
			en_q <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_q <= MODE_VBLANK;
		end else if (TEAR_ON_CMD) begin
			mode_q <= tear_mode_t'(TEAR_MODE_PARAM);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Waveform selection
	// Porch lines form the vertical high period
	assign vblank = (state != ST_ACTIVE);

	always_comb begin
		out_d = 1'b0;
		if (!en_q || SLEEP_IN) begin
			out_d = 1'b0;
		end else if (mode_q == MODE_VBLANK) begin
			out_d = vblank;
		end else begin
			out_d = vblank || in_hblank;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	assign TEAR_SYNC_OUT = out_q;
	assign TEAR_ENABLED = en_q;
	assign TEAR_MODE = mode_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	logic [CNT_W-1:0] hi_cnt_q;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			hi_cnt_q <= 16'h0000;
		end else if (out_q && state == ST_ACTIVE) begin
			hi_cnt_q <= hi_cnt_q + 16'h0001;
		end else begin
			hi_cnt_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Per-field pulse counting
	scan_state_t prev_state_q;
	logic out_prev_q;
	logic field_start;
	logic vb_ok;
	logic vh_ok;
	logic [LINE_W-1:0] rise_cnt_q;
	logic [LINE_W-1:0] fall_cnt_q;
	logic vclean_q;
	logic hclean_q;

	assign field_start = (state == ST_FRONT) && (prev_state_q == ST_ACTIVE);
	assign vb_ok = en_q && !SLEEP_IN && (mode_q == MODE_VBLANK);
	assign vh_ok = en_q && !SLEEP_IN && (mode_q == MODE_VHBLANK) &&
		(hblank_eff < LINE_CYCLES);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			prev_state_q <= ST_BACK;
			out_prev_q <= 1'b0;
		end else begin
			prev_state_q <= state;
			out_prev_q <= out_q;
		end
	end

	// Rising edges over one field, vblank mode
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rise_cnt_q <= 9'h000;
			vclean_q <= 1'b0;
		end else if (field_start) begin
			rise_cnt_q <= 9'h000;
			vclean_q <= vb_ok;
		end else begin
			if (!out_prev_q && out_q) begin
				rise_cnt_q <= rise_cnt_q + 9'h001;
			end
			if (!vb_ok) begin
				vclean_q <= 1'b0;
			end
		end
	end

	// Falling edges over one field, line mode
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			fall_cnt_q <= 9'h000;
			hclean_q <= 1'b0;
		end else if (field_start) begin
			fall_cnt_q <= 9'h000;
			hclean_q <= vh_ok;
		end else begin
			if (out_prev_q && !out_q) begin
				fall_cnt_q <= fall_cnt_q + 9'h001;
			end
			if (!vh_ok) begin
				hclean_q <= 1'b0;
			end
		end
	end

	AST_ONE_VPULSE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		field_start && vclean_q |-> rise_cnt_q == 9'h001)
		else $error("vertical pulse count wrong");
	AST_LINE_PULSES: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		field_start && hclean_q |-> fall_cnt_q == LINE_W'(LINES_PER_FIELD))
		else $error("line pulse count wrong");
	AST_SLEEP_KEEPS_EN: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		SLEEP_IN && !TEAR_ON_CMD && !TEAR_OFF_CMD |=> en_q == $past(en_q))
		else $error("sleep changed enable");
	AST_HBLANK_CAP: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		hblank_eff <= CNT_W'(LINE_HIGH_MAX_CYC))
		else $error("line high setting above ceiling");

	AST_OFF_LOW: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!en_q |=> !TEAR_SYNC_OUT) else $error("output high while off");
	AST_ON_ENABLES: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		TEAR_ON_CMD |=> en_q) else $error("on command ignored");
	AST_OFF_DISABLES: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		TEAR_OFF_CMD && !TEAR_ON_CMD |=> !en_q ##1 !TEAR_SYNC_OUT)
		else $error("off command ignored");
	AST_MODE_LATCH: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		TEAR_ON_CMD |=> mode_q == $past(TEAR_MODE_PARAM))
		else $error("mode not taken");
	AST_SLEEP_LOW: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		SLEEP_IN |=> !TEAR_SYNC_OUT) else $error("output high in sleep");
	AST_VB_MODE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		en_q && !SLEEP_IN && mode_q == MODE_VBLANK |=>
		TEAR_SYNC_OUT == $past(state != ST_ACTIVE))
		else $error("vblank waveform wrong");
	AST_VH_MODE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		en_q && !SLEEP_IN && mode_q == MODE_VHBLANK && state == ST_ACTIVE |=>
		TEAR_SYNC_OUT == $past(in_hblank)) else $error("hblank waveform wrong");
	AST_PORCH_HIGH: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		en_q && !SLEEP_IN && state != ST_ACTIVE |=> TEAR_SYNC_OUT)
		else $error("vertical high cut short");
	AST_LINE_MAX: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		hi_cnt_q <= CNT_W'(LINE_HIGH_MAX_CYC)) else $error("line high too long");

	COV_VB: cover property (@(posedge REF_CLK) disable iff (!RSTN)
		mode_q == MODE_VBLANK && $rose(TEAR_SYNC_OUT));
	COV_VH: cover property (@(posedge REF_CLK) disable iff (!RSTN)
		mode_q == MODE_VHBLANK && state == ST_ACTIVE && $rose(TEAR_SYNC_OUT));
	COV_SLEEP: cover property (@(posedge REF_CLK) disable iff (!RSTN)
		en_q && SLEEP_IN);
	COV_OFF: cover property (@(posedge REF_CLK) disable iff (!RSTN)
		en_q ##1 !en_q);
	COV_FIELD: cover property (@(posedge REF_CLK) disable iff (!RSTN)
		field_start && hclean_q);
endmodule // tear_sync_output

// ==== tear_sync_pkg.sv ====
// Constants and types for the tearing-sync output generator
package tear_sync_pkg;
	localparam int CLK_MHZ = 100;
	localparam int LINES_PER_FIELD = 220;
	localparam int LINE_W = 9;
	localparam int PORCH_W = 8;
	localparam int CNT_W = 16;
	localparam int LINE_HIGH_MAX_US = 500;
	localparam int LINE_HIGH_MAX_CYC = LINE_HIGH_MAX_US * CLK_MHZ;
	localparam logic [CNT_W-1:0] LINE_CYC_DEF = 16'h0190;
	localparam logic [CNT_W-1:0] LINE_HBLANK_DEF = 16'h0050;
	localparam logic [PORCH_W-1:0] BACK_PORCH_DEF = 8'h06;
	localparam logic [PORCH_W-1:0] FRONT_PORCH_DEF = 8'h04;
	localparam logic [LINE_W-1:0] LINE_LAST =
		LINE_W'(LINES_PER_FIELD - 1);

	typedef enum logic {
		MODE_VBLANK = 1'b0,
		MODE_VHBLANK = 1'b1
	} tear_mode_t;

	typedef enum logic [1:0] {
		ST_BACK = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_FRONT = 2'b10
	} scan_state_t;
endpackage

// ==== scan_timer.sv ====
// Line and field timing generator for the panel scan
`timescale 1ns/100ps
module scan_timer
	import tear_sync_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [CNT_W-1:0] line_cyc,
	input wire logic [CNT_W-1:0] line_hblank,
	input wire logic [PORCH_W-1:0] back_porch_lines,
	input wire logic [PORCH_W-1:0] front_porch_lines,
	output logic line_end,
	output logic in_hblank,
	output logic [LINE_W-1:0] line_idx,
	output scan_state_t state
);
	logic [CNT_W-1:0] cyc_q;
	logic [LINE_W-1:0] line_q;
	scan_state_t state_q;

	assign line_end = (cyc_q >= line_cyc - 16'h0001);
	assign in_hblank = (cyc_q < line_hblank);
	assign line_idx = line_q;
	assign state = state_q;

	////////////////////////////////////////////////////////////////////
	// Cycle count within a line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= 16'h0000;
		end else if (line_end) begin
			cyc_q <= 16'h0000;
		end else begin
			cyc_q <= cyc_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Line count and field phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 9'h000;
			state_q <= ST_BACK;
		end else if (line_end) begin
			case (state_q)
				ST_BACK: begin
					if (line_q + 9'h001 >= {1'b0, back_porch_lines}) begin
						line_q <= 9'h000;
						state_q <= ST_ACTIVE;
					end else begin
						line_q <= line_q + 9'h001;
					end
				end
				ST_ACTIVE: begin
					if (line_q == LINE_LAST) begin
						line_q <= 9'h000;
						state_q <= ST_FRONT;
					end else begin
						line_q <= line_q + 9'h001;
					end
				end
				ST_FRONT: begin
					if (line_q + 9'h001 >= {1'b0, front_porch_lines}) begin
						line_q <= 9'h000;
						state_q <= ST_BACK;
					end else begin
						line_q <= line_q + 9'h001;
					end
				end
				default: begin
					line_q <= 9'h000;
					state_q <= ST_BACK;
				end
			endcase
		end
	end
endmodule // scan_timer

// ==== host_model.sv ====
// Host model watching the tearing-sync line
`timescale 1ns/100ps
module host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_in,
	input wire logic meas_en,
	output logic [31:0] hi_q,
	output logic [31:0] run_max_q,
	output logic wr_start
);
	logic [31:0] run_q;
	logic sync_q;
	// Write burst starts on each rising sync edge
	assign wr_start = sync_in & ~sync_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= 1'b0;
			run_q <= '0;
		end else begin
			sync_q <= sync_in;
			run_q <= sync_in ? run_q + 1 : '0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= '0;
			run_max_q <= '0;
		end else if (!meas_en) begin
			hi_q <= '0;
			run_max_q <= '0;
		end else begin
			hi_q <= hi_q + 32'(sync_in);
			if (sync_in && run_q + 1 > run_max_q) begin
				run_max_q <= run_q + 1;
			end
		end
	end
endmodule // host_model

// ==== testbench.sv ====
// Self-checking bench for the tearing-sync generator
`timescale 1ns/100ps
module testbench
	import tear_sync_pkg::*;
;
	localparam int L = 8;
	localparam int H = 3;
	logic clk = 0, rstn = 0, on = 0, off = 0, prm = 0, slp = 0, meas = 0;
	logic [PORCH_W-1:0] bp = 8'h02, fp = 8'h02;
	logic sync, en_o, mode_o, m;
	logic [31:0] hi, rmax;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	tear_sync_output i_tear_sync_output (.REF_CLK(clk), .RSTN(rstn),
		.TEAR_ON_CMD(on), .TEAR_OFF_CMD(off), .TEAR_MODE_PARAM(prm),
		.SLEEP_IN(slp), .BACK_PORCH_LINES(bp), .FRONT_PORCH_LINES(fp),
		.LINE_CYCLES(16'h0008), .LINE_HBLANK_CYCLES(16'h0003),
		.TEAR_SYNC_OUT(sync), .TEAR_ENABLED(en_o), .TEAR_MODE(mode_o));
	host_model i_host_model (.clk(clk), .rst_n(rstn), .sync_in(sync),
		.meas_en(meas), .hi_q(hi), .run_max_q(rmax), .wr_start());
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic int fld();
		return (bp + fp + LINES_PER_FIELD) * L;
	endfunction
	function automatic logic [31:0] exp_hi(logic md);
		return 2 * ((bp + fp) * L + md * LINES_PER_FIELD * H);
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic cmd(logic o, logic f, logic p);
		@(negedge clk);
		on = o;
		off = f;
		prm = p;
		@(negedge clk);
		on = 0;
		off = 0;
		repeat (2) @(negedge clk);
	endtask
	task automatic measure();
		repeat (2 * fld()) @(negedge clk);
		meas = 1;
		repeat (2 * fld()) @(negedge clk);
		meas = 0;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h62f5));
		repeat (20) @(negedge clk);
		rstn = 1;
		measure();
		chk("off_high", 0, hi);
		chk("enabled", 0, en_o);
		for (int i = 0; i < 5; i++) begin
			m = (i < 2) ? i[0] : 1'($urandom_range(1, 0));
			bp = 8'($urandom_range(8, 1));
			fp = (i == 0) ? 8'h01 : 8'($urandom_range(8, 1));
			cmd(1, 0, m);
			chk("mode", 32'(m), 32'(mode_o));
			measure();
			chk("high_cycles", exp_hi(m), hi);
			chk("vrun", 1, 32'(rmax >= (bp + fp) * L));
		end
		slp = 1;
		measure();
		chk("sleep_high", 0, hi);
		slp = 0;
		cmd(1, 1, 0);
		chk("on_wins", 1, 32'(en_o));
		cmd(0, 1, 0);
		chk("disabled", 0, 32'(en_o));
		measure();
		chk("off_after", 0, hi);
		conclude();
	end
endmodule // testbench
